// File: common/watchdog_consts.vh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH

// Register byte addresses
`define WD_CTRL_ADDR      32'h0000_00d8
`define WD_EIE_ADDR       32'h0000_00e8
`define WD_EIP_ADDR       32'h0000_00f8
`define WD_KEY_ADDR       32'h0000_0000
`define WD_IRQ_STAT_ADDR  32'h0000_0004
`define WD_IRQ_MASK_ADDR  32'h0000_0008

// Control register fields
`define WD_BAUD_DOUBLE_BIT  7
`define WD_POR_BIT          6
`define WD_IRQ_FLAG_BIT     3
`define WD_RESET_CAUSE_BIT  2
`define WD_RESET_ARM_BIT    1
`define WD_RESTART_BIT      0

// Interrupt enable and priority fields
`define WD_EIE_IRQ_EN_BIT   4
`define WD_EIP_IRQ_PRI_BIT  4
`define WD_EIE_RSVD_READ    3'h7
`define WD_EIP_RSVD_READ    3'h0
`define WD_EIE_RESET        5'h00
`define WD_EIP_RESET        5'h00

// Sticky status fields
`define WD_STAT_TIMEOUT_BIT 0
`define WD_STAT_WDRESET_BIT 1
`define WD_STAT_WIDTH       2

// Protected-write key sequence
`define WD_KEY_FIRST        8'haa
`define WD_KEY_SECOND       8'h55
`define WD_KEY_WINDOW_MC    3
`define WD_CLKS_PER_MC      4
`define WD_KEY_WINDOW_CLKS  (`WD_KEY_WINDOW_MC * `WD_CLKS_PER_MC)

// Time-out to reset delay, in clocks
`define WD_RESET_DELAY_CLKS 512

// Default time-out interval, in clocks
`define WD_TIMEOUT_CLKS     131072

// AHB encodings
`define AHB_TRANS_NONSEQ    2'h2
`define AHB_RESP_OKAY       1'h0

`endif

// File: design/watchdog_control_and_flags.v
// Watchdog control, reset-cause flags and protected writes behind an AHB-Lite slave
`timescale 1ns/100ps
`include "watchdog_consts.vh"

module watchdog_control_and_flags #(
  parameter TIMEOUT_CLKS = `WD_TIMEOUT_CLKS,
  parameter CNT_W        = 32
) (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  // Reset request pins
  input  wire        extResetPin,
  input  wire        powerFailPin,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Watchdog and core outputs
  output reg         wdResetOut,
  output reg         wdIrq,
  output reg         wdIrqPriority,
  output reg         secondPortBaudDouble,
  output reg         irq
);

  localparam ST_COUNT = 1'b0;
  localparam ST_DELAY = 1'b1;
  localparam [CNT_W-1:0] TIMEOUT_LAST = TIMEOUT_CLKS - 1;
  localparam integer DELAY_LAST_I = `WD_RESET_DELAY_CLKS - 1;
  localparam integer KEY_WINDOW_I = `WD_KEY_WINDOW_CLKS;
  localparam [9:0] DELAY_LAST = DELAY_LAST_I[9:0];
  localparam [3:0] KEY_WINDOW = KEY_WINDOW_I[3:0];

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg [1:0] extSync;
  reg [1:0] pfSync;
  wire      extReset  = extSync[1];
  wire      powerFail = pfSync[1];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      extSync <= 2'h0;
      pfSync  <= 2'h0;
    end else if (ce) begin
      extSync <= {extSync[0], extResetPin};
      pfSync  <= {pfSync[0], powerFailPin};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bus data phase

  reg        dActive;
  reg        dWrite;
  reg [31:0] dAddr;

  function isReg;
    input [31:0] addr;
    input [31:0] offset;
    begin
      isReg = (addr == offset);
    end
  endfunction

  wire addrPhase = hsel && hready && (htrans == `AHB_TRANS_NONSEQ);
  wire wrNow     = dActive && dWrite;
  wire [7:0] wrByte = hwdata[7:0];
  wire wrCtrl = wrNow && isReg(dAddr, `WD_CTRL_ADDR);
  wire wrEie  = wrNow && isReg(dAddr, `WD_EIE_ADDR);
  wire wrEip  = wrNow && isReg(dAddr, `WD_EIP_ADDR);
  wire wrKey  = wrNow && isReg(dAddr, `WD_KEY_ADDR);
  wire wrStat = wrNow && isReg(dAddr, `WD_IRQ_STAT_ADDR);
  wire wrMask = wrNow && isReg(dAddr, `WD_IRQ_MASK_ADDR);

  // One wait state on every NONSEQ transfer so read data comes from a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dActive   <= 1'b0;
      dWrite    <= 1'b0;
      dAddr     <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= `AHB_RESP_OKAY;
    end else if (ce) begin
      hresp <= `AHB_RESP_OKAY;
      if (addrPhase) begin
        dActive   <= 1'b1;
        dWrite    <= hwrite;
        dAddr     <= {haddr[31:2], 2'h0};
        hreadyout <= 1'b0;
      end else if (dActive) begin
        dActive   <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Protected-write key

  reg       keyFirstSeen;
  reg [3:0] keyWindow;
  wire      keyOpen = (keyWindow != 4'h0);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      keyFirstSeen <= 1'b0;
      keyWindow    <= 4'h0;
    end else if (ce) begin
      if (wrKey && keyFirstSeen && wrByte == `WD_KEY_SECOND) begin
        keyWindow <= KEY_WINDOW;
      end else if (keyOpen) begin
        keyWindow <= keyWindow - 4'h1;
      end
      // Any other write in between breaks the sequence
      if (wrNow) begin
        keyFirstSeen <= wrKey && (wrByte == `WD_KEY_FIRST);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Control, enable and priority registers

  reg       porFlag;
  reg       irqFlag;
  reg       resetCauseFlag;
  reg       resetArm;
  reg       restartBit;
  reg [4:0] extended_interrupt_enable;
  reg [4:0] extended_interrupt_priority;
  wire      timeoutHit;
  wire      wdFire;

  wire protWr = wrCtrl && keyOpen;
  wire irqEnable = extended_interrupt_enable[`WD_EIE_IRQ_EN_BIT];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      secondPortBaudDouble <= 1'b0;
      porFlag              <= 1'b1;
      irqFlag              <= 1'b0;
      resetCauseFlag       <= 1'b0;
      resetArm             <= 1'b0;
      restartBit           <= 1'b0;
      extended_interrupt_enable                  <= `WD_EIE_RESET;
      extended_interrupt_priority                  <= `WD_EIP_RESET;
    end else if (ce) begin
      if (powerFail || extReset || wdFire) begin
        // Pattern 0x000xx0: power-on flag and reset arm kept
        secondPortBaudDouble <= 1'b0;
        irqFlag              <= 1'b0;
        restartBit           <= 1'b0;
        extended_interrupt_enable                  <= `WD_EIE_RESET;
        extended_interrupt_priority                  <= `WD_EIP_RESET;
        if (powerFail) begin
          resetCauseFlag <= 1'b0;
        end else if (wdFire) begin
          resetCauseFlag <= 1'b1;
        end
      end else begin
        if (wrCtrl) begin
          secondPortBaudDouble <= wrByte[`WD_BAUD_DOUBLE_BIT];
          resetCauseFlag       <= wrByte[`WD_RESET_CAUSE_BIT];
        end
        if (protWr) begin
          porFlag  <= wrByte[`WD_POR_BIT];
          resetArm <= wrByte[`WD_RESET_ARM_BIT];
        end
        // Time-out beats a clearing write in the same cycle
        if (timeoutHit) begin
          irqFlag <= 1'b1;
        end else if (protWr) begin
          irqFlag <= wrByte[`WD_IRQ_FLAG_BIT];
        end
        // Restart reads back as 1 for a single cycle
        restartBit <= protWr && wrByte[`WD_RESTART_BIT];
        if (wrEie) begin
          extended_interrupt_enable <= wrByte[4:0];
        end
        if (wrEip) begin
          extended_interrupt_priority <= wrByte[4:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Watchdog counter

  reg             wdState;
  reg [CNT_W-1:0] wdCount;
  reg [9:0]       delayCount;
  wire            restartReq = protWr && wrByte[`WD_RESTART_BIT];
  wire            anyReset   = powerFail || extReset || wdFire;

  assign timeoutHit = (wdState == ST_COUNT) && (wdCount == TIMEOUT_LAST) && !restartReq && !anyReset;
  // Fires only while armed, so an unarmed watchdog leaves the cause flag alone
  assign wdFire = (wdState == ST_DELAY) && (delayCount == DELAY_LAST) && resetArm && !restartReq;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdState    <= ST_COUNT;
      wdCount    <= {CNT_W{1'b0}};
      delayCount <= 10'h000;
    end else if (ce) begin
      if (restartReq || anyReset) begin
        wdState    <= ST_COUNT;
        wdCount    <= {CNT_W{1'b0}};
        delayCount <= 10'h000;
      end else begin
        case (wdState)
          ST_COUNT: begin
            if (timeoutHit) begin
              wdState    <= ST_DELAY;
              delayCount <= 10'h000;
            end else begin
              wdCount <= wdCount + {{(CNT_W-1){1'b0}}, 1'b1};
            end
          end
          ST_DELAY: begin
            // Unarmed: the period simply starts over after the delay
            if (delayCount == DELAY_LAST) begin
              wdState <= ST_COUNT;
              wdCount <= {CNT_W{1'b0}};
            end else begin
              delayCount <= delayCount + 10'h001;
            end
          end
          default: begin
            wdState <= ST_COUNT;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sticky status and mask

  reg [`WD_STAT_WIDTH-1:0] irqStatus;
  reg [`WD_STAT_WIDTH-1:0] irqMask;
  wire [`WD_STAT_WIDTH-1:0] irqEvents = {wdFire, timeoutHit};
  wire [`WD_STAT_WIDTH-1:0] irqClear  = wrStat ? wrByte[`WD_STAT_WIDTH-1:0] : {`WD_STAT_WIDTH{1'b0}};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus <= {`WD_STAT_WIDTH{1'b0}};
      irqMask   <= {`WD_STAT_WIDTH{1'b0}};
    end else if (ce) begin
      // Set wins over a write-one clear in the same cycle
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
      if (wrMask) begin
        irqMask <= wrByte[`WD_STAT_WIDTH-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data and outputs

  reg [7:0] next_readByte;

  always @* begin
    next_readByte = 8'h00;
    if (isReg(dAddr, `WD_CTRL_ADDR)) begin
      next_readByte = {secondPortBaudDouble, porFlag, 2'h0,
                       irqFlag, resetCauseFlag, resetArm, restartBit};
    end else if (isReg(dAddr, `WD_EIE_ADDR)) begin
      next_readByte = {`WD_EIE_RSVD_READ, extended_interrupt_enable};
    end else if (isReg(dAddr, `WD_EIP_ADDR)) begin
      next_readByte = {`WD_EIP_RSVD_READ, extended_interrupt_priority};
    end else if (isReg(dAddr, `WD_KEY_ADDR)) begin
      next_readByte = {7'h00, keyOpen};
    end else if (isReg(dAddr, `WD_IRQ_STAT_ADDR)) begin
      next_readByte = {6'h00, irqStatus};
    end else if (isReg(dAddr, `WD_IRQ_MASK_ADDR)) begin
      next_readByte = {6'h00, irqMask};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata        <= 32'h0000_0000;
      wdResetOut    <= 1'b0;
      wdIrq         <= 1'b0;
      wdIrqPriority <= 1'b0;
      irq           <= 1'b0;
    end else if (ce) begin
      if (dActive && !dWrite) begin
        hrdata <= {24'h000000, next_readByte};
      end
      wdResetOut    <= wdFire;
      wdIrq         <= irqFlag && irqEnable;
      wdIrqPriority <= extended_interrupt_priority[`WD_EIP_IRQ_PRI_BIT];
      irq           <= |(irqStatus & irqMask);
    end
  end

  // Serial port consumes secondPortBaudDouble in modes 1 to 3 only

endmodule

// File: verification/watchdog_control_and_flags_chk.sv
// Port-level assertion checker for the watchdog control block
`timescale 1ns/100ps
module watchdog_control_and_flags_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  input wire        ce,
  // Bus and pins
  input wire        extResetPin,
  input wire        powerFailPin,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Outputs
  input wire        wdResetOut,
  input wire        wdIrq,
  input wire        wdIrqPriority,
  input wire        secondPortBaudDouble,
  input wire        irq
);
  reg [7:0] recentEv;
  wire      take = hsel & hready & (htrans == 2'h2) & ce;
  // Any cause that may legally move a register-backed output
  always @(posedge clk or posedge rst) begin
    if (rst)
      recentEv <= 8'h00;
    else
      recentEv <= {recentEv[6:0], (take & hwrite) | extResetPin | powerFailPin | wdResetOut};
  end
  a_resp_okay: assert property (@(posedge clk) disable iff (rst) hresp == 1'b0)
    else $error("hresp not OKAY");
  a_ready_low: assert property (@(posedge clk) disable iff (rst) take |=> !hreadyout ##1 hreadyout)
    else $error("hreadyout not low for one cycle");
  a_ready_cause: assert property (@(posedge clk) disable iff (rst) $fell(hreadyout) |-> $past(take))
    else $error("hreadyout fell without request");
  a_fire_pulse: assert property (@(posedge clk) disable iff (rst) wdResetOut |=> !wdResetOut)
    else $error("watchdog reset pulse too long");
  a_upper_zero: assert property (@(posedge clk) disable iff (rst) hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_release_quiet: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> hreadyout && !irq && !wdResetOut && !wdIrq)
    else $error("outputs not at reset values");
  // A watchdog reset moves secondPortBaudDouble in the same cycle as its own pulse, before the history sees it
  a_prio_cause: assert property (@(posedge clk) disable iff (rst)
    $changed(wdIrqPriority) |-> (|recentEv) || wdResetOut)
    else $error("priority changed without cause");
  a_baud_cause: assert property (@(posedge clk) disable iff (rst)
    $changed(secondPortBaudDouble) |-> (|recentEv) || wdResetOut)
    else $error("baud double changed without cause");
endmodule
bind watchdog_control_and_flags watchdog_control_and_flags_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
  .extResetPin(extResetPin), .powerFailPin(powerFailPin), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wdResetOut(wdResetOut),
  .wdIrq(wdIrq), .wdIrqPriority(wdIrqPriority), .secondPortBaudDouble(secondPortBaudDouble), .irq(irq));

// File: verification/watchdog_control_and_flags_tb.sv
// Self-checking testbench for the watchdog control block
`timescale 1ns/100ps
`include "watchdog_consts.vh"
module watchdog_control_and_flags_tb;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         extResetPin = 1'b0;
  reg         powerFailPin = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        wdResetOut;
  wire        wdIrq;
  wire        wdIrqPriority;
  wire        secondPortBaudDouble;
  wire        irq;
  integer     err_count = 0;
  integer     n_tests = 0;
  integer     cyc = 0;
  integer     tIrq;
  integer     i;
  reg  [31:0] seed = 32'h00000d67;
  reg  [31:0] rd;
  reg  [31:0] v;
  reg         sawReset = 1'b0;
  // Short time-out keeps the run brief
  watchdog_control_and_flags #(.TIMEOUT_CLKS(64)) DUT (.clk(clk), .rst(rst), .ce(1'b1),
    .extResetPin(extResetPin), .powerFailPin(powerFailPin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wdResetOut(wdResetOut), .wdIrq(wdIrq),
    .wdIrqPriority(wdIrqPriority), .secondPortBaudDouble(secondPortBaudDouble), .irq(irq));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdResetOut)
      sawReset <= 1'b1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task stop_test;
    begin
      if (err_count == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= `AHB_TRANS_NONSEQ;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
    end
  endtask
  task chk(input [31:0] got, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (got !== e) begin
        $display("MISMATCH at %0t: got %h expected %h", $time, got, e);
        err_count = err_count + 1;
      end
    end
  endtask
  task rdchk(input [31:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task key;
    begin
      bus(1'b1, `WD_KEY_ADDR, `WD_KEY_FIRST);
      bus(1'b1, `WD_KEY_ADDR, `WD_KEY_SECOND);
    end
  endtask
  task pulse(input pf);
    begin
      @(posedge clk);
      extResetPin  <= !pf;
      powerFailPin <= pf;
      repeat (3) @(posedge clk);
      extResetPin  <= 1'b0;
      powerFailPin <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdchk(`WD_CTRL_ADDR, 32'h40);
    rdchk(`WD_EIE_ADDR, 32'he0);
    rdchk(`WD_EIP_ADDR, 32'h0);
    rdchk(32'h00000100, 32'h0);
    bus(1'b1, `WD_CTRL_ADDR, 32'hff);
    rdchk(`WD_CTRL_ADDR, 32'hc4);
    chk(secondPortBaudDouble, 32'h1);
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      v = (seed & 32'hc5) | 32'h1;
      key;
      bus(1'b1, `WD_CTRL_ADDR, v);
      rdchk(`WD_CTRL_ADDR, v & 32'hc4);
      chk(secondPortBaudDouble, v[7]);
    end
    // Foreign write between key halves must break the sequence
    bus(1'b1, `WD_KEY_ADDR, `WD_KEY_FIRST);
    bus(1'b1, `WD_EIE_ADDR, 32'h0);
    bus(1'b1, `WD_KEY_ADDR, `WD_KEY_SECOND);
    bus(1'b1, `WD_CTRL_ADDR, 32'h02);
    rdchk(`WD_CTRL_ADDR, v & 32'h40);
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      bus(1'b1, `WD_EIE_ADDR, seed);
      rdchk(`WD_EIE_ADDR, 32'he0 | (seed & 32'h1f));
      bus(1'b1, `WD_EIP_ADDR, seed >> 8);
      rdchk(`WD_EIP_ADDR, (seed >> 8) & 32'h1f);
      chk(wdIrqPriority, seed[12]);
    end
    bus(1'b1, `WD_EIE_ADDR, 32'h10);
    key;
    bus(1'b1, `WD_CTRL_ADDR, 32'h03);
    bus(1'b1, `WD_IRQ_STAT_ADDR, 32'h3);
    bus(1'b1, `WD_IRQ_MASK_ADDR, 32'h1);
    i = 0;
    while (irq !== 1'b1 && i < 200) begin
      @(posedge clk);
      i = i + 1;
    end
    tIrq = cyc;
    chk(wdIrq, 32'h1);
    rdchk(`WD_CTRL_ADDR, 32'h0a);
    i = 0;
    while (wdResetOut !== 1'b1 && i < 700) begin
      @(posedge clk);
      i = i + 1;
    end
    chk(cyc - tIrq >= 508 && cyc - tIrq <= 516, 32'h1);
    rdchk(`WD_CTRL_ADDR, 32'h06);
    rdchk(`WD_IRQ_STAT_ADDR, 32'h3);
    bus(1'b1, `WD_IRQ_MASK_ADDR, 32'h0);
    rdchk(`WD_IRQ_STAT_ADDR, 32'h3);
    chk(irq, 32'h0);
    bus(1'b1, `WD_IRQ_STAT_ADDR, 32'h3);
    rdchk(`WD_IRQ_STAT_ADDR, 32'h0);
    key;
    bus(1'b1, `WD_CTRL_ADDR, 32'h87);
    rdchk(`WD_CTRL_ADDR, 32'h86);
    pulse(1'b0);
    rdchk(`WD_CTRL_ADDR, 32'h06);
    rdchk(`WD_EIE_ADDR, 32'he0);
    pulse(1'b1);
    rdchk(`WD_CTRL_ADDR, 32'h02);
    key;
    bus(1'b1, `WD_CTRL_ADDR, 32'h01);
    sawReset = 1'b0;
    repeat (700) @(posedge clk);
    chk(sawReset, 32'h0);
    rdchk(`WD_CTRL_ADDR, 32'h08);
    chk(wdIrq, 32'h0);
    stop_test;
  end
endmodule
